/* File: inc/seq_pkg.sv */
// shared constants for the program sequencer block
// assumes a single 250 MHz core clock and an active-low async reset
package seq_pkg;
    localparam int PC_W          = 13;
    localparam int WORD_W        = 16;
    localparam int IDX_W         = 4;
    localparam int SLOTS         = 15;
    localparam int PAGE_HI       = 12;
    localparam int PAGE_LO       = 11;
    localparam int WAKE_W        = 4;
    localparam int PORT_W        = 4;
    localparam logic [PC_W-1:0]  RESET_PC     = 13'h0000;
    localparam logic [PC_W-1:0]  VEC_EXT      = 13'h0004;
    localparam logic [PC_W-1:0]  VEC_TMR      = 13'h0003;
    localparam logic [PC_W-1:0]  VEC_PER      = 13'h0002;
    localparam logic [PC_W-1:0]  VEC_SER      = 13'h0001;
    localparam logic [PC_W-1:0]  SMALL_TOP    = 13'h17FF;
    localparam logic [PC_W-1:0]  LARGE_TOP    = 13'h1FFF;
    localparam logic [IDX_W-1:0] IDX_RESET    = 4'hF;
    localparam logic [IDX_W-1:0] IDX_NOSLOT   = 4'hF;
    localparam logic [PC_W-1:0]  UNDEF_RET    = 13'h0000;

    // instruction class presented by the decoder
    typedef enum logic [3:0] {
        OP_NEXT      = 4'h0,
        OP_JUMP      = 4'h1,
        OP_JUMP_IND  = 4'h2,
        OP_CALL      = 4'h3,
        OP_CALL_IND  = 4'h4,
        OP_TABLE     = 4'h5,
        OP_RET       = 4'h6,
        OP_RET_SKIP  = 4'h7,
        OP_RET_INT   = 4'h8,
        OP_STOP      = 4'h9,
        OP_HALT      = 4'hA
    } op_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_TABLE = 2'b01,
        ST_HALT  = 2'b10,
        ST_STOP  = 2'b11
    } seq_state_t;
endpackage : seq_pkg

/* File: logic/return_stack.sv */
// fifteen-slot return address store, addressed by the stack index
// assumes the sequencer gives one write strobe per push
module return_stack #(
    parameter int DEPTH = seq_pkg::SLOTS
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // access
    input  wire logic [seq_pkg::IDX_W-1:0]  idx,
    input  wire logic                       wr_en,
    input  wire logic [seq_pkg::PC_W-1:0]   wr_data,
    output logic      [seq_pkg::PC_W-1:0]   rd_data
);
    import seq_pkg::*;

    logic [PC_W-1:0] slot_r [DEPTH];
    logic [PC_W-1:0] slot_nxt [DEPTH];

    // per-slot next value; index 15 has no storage behind it
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            slot_nxt[i] = slot_r[i];
            if (wr_en && idx == IDX_W'(i)) begin
                slot_nxt[i] = wr_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                slot_r[i] <= '0;
            end
        end else begin
            slot_r <= slot_nxt;
        end
    end

    // the missing slot reads a fixed filler rather than real data
    always_comb begin
        if (idx == IDX_NOSLOT || int'(idx) >= DEPTH) begin
            rd_data = UNDEF_RET;
        end else begin
            rd_data = slot_r[idx];
        end
    end
endmodule // return_stack

/* File: logic/pin_sync.sv */
// three-stage synchroniser for a bus of pin inputs
// a change is accepted once stages two and three agree
module pin_sync #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
    logic [W-1:0] lvl_nxt;

    // per bit: update only when the two later stages agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            lvl_r <= '0;
        end else begin
            s1_r  <= pin;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign level = lvl_r;
endmodule // pin_sync

/* File: logic/program_sequencer.sv */
// program counter, next-address choice, return stack and pin defaults
// assumes the decoder presents one instruction class per fetched word
// How it works
// - program counter is 13 bits, bits 12 and 11 pick the page
// - each fetch reads one 16-bit word per address
// - indirect jump reaches whole space, 17FFH or 1FFFH top by variant
// - direct call clears page bits, target in page 0
// - direct jump loads all 13 bits including page from operand
// - indirect jump, indirect call and table read load from pointer register
// - all three return kinds load from slot picked by stack index
// - interrupt vectors 4,3,2,1 by source, highest priority first
// - table read places the word at pointer address in constant buffer
// - addresses above 17FFH unpopulated on small variant; flagged
// - fifteen 13-bit return slots, slot 15 has no storage
// - call, interrupt and table read each push a return address
// - slot accessed is always the one the stack index selects
// - a high wake-up input releases halt and clock stop
// - wake-up pins pulled down after reset, kept on clock stop
// - bidirectional ports become inputs on resets and clock stop
// - high test pin enters factory test mode
// - push decrements index then writes; return reads then increments
// - any reset starts at address zero
// - index 15 selects an undefined value
module program_sequencer #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // clock and reset
    input  wire logic                          CORE_CLK,
    input  wire logic                          RST_N,
    // fault reset from watchdog or stack check
    input  wire logic                          FAULT_RESET,
    // decoder
    input  wire seq_pkg::op_t                  OP_CLASS,
    input  wire logic                          OP_VALID,
    input  wire logic [seq_pkg::PC_W-1:0]      OP_ADDR,
    input  wire logic [seq_pkg::PC_W-1:0]      INDIRECT_POINTER_REG,
    // interrupt requests, one pulse when accepted
    input  wire logic                          IRQ_EXT,
    input  wire logic                          IRQ_TMR,
    input  wire logic                          IRQ_PER,
    input  wire logic                          IRQ_SER,
    // program memory
    input  wire logic [seq_pkg::WORD_W-1:0]    ROM_DATA,
    output logic      [seq_pkg::PC_W-1:0]      ROM_ADDR,
    output logic      [seq_pkg::WORD_W-1:0]    FETCH_WORD,
    output logic                               FETCH_VALID,
    // constant buffer
    output logic      [seq_pkg::WORD_W-1:0]    CONSTANT_BUFFER,
    output logic                               BUFFER_LOAD,
    // status
    output logic      [seq_pkg::PC_W-1:0]      PC,
    output logic      [seq_pkg::IDX_W-1:0]     STACK_INDEX,
    output logic                               HALTED,
    output logic                               STOPPED,
    output logic                               ADDR_FAULT,
    // pins
    input  wire logic [seq_pkg::WAKE_W-1:0]    WAKEUP_INPUT_PORT,
    input  wire logic                          TEST_PIN,
    output logic      [seq_pkg::WAKE_W-1:0]    WAKEUP_PULLDOWN_EN,
    output logic      [seq_pkg::PORT_W-1:0]    PORT_DIR_INPUT,
    input  wire logic [seq_pkg::PORT_W-1:0]    PORT_DIR_SET,
    input  wire logic                          PORT_DIR_WR,
    output logic                               TEST_MODE
);
    import seq_pkg::*;

    localparam logic [PC_W-1:0] MEM_TOP = LARGE_VARIANT ? LARGE_TOP : SMALL_TOP;

    // sequencer state
    seq_state_t          state_r, state_nxt;
    logic [PC_W-1:0]     pc_r, pc_nxt;
    logic [IDX_W-1:0]    idx_r, idx_nxt;
    logic [PC_W-1:0]     addr_r, addr_nxt;
    logic                afault_r, afault_nxt;
    logic                halted_r, halted_nxt;
    logic                stopped_r, stopped_nxt;

    // fetch and buffer
    logic [WORD_W-1:0]   fetch_r, fetch_nxt;
    logic                fvalid_r, fvalid_nxt;
    logic [WORD_W-1:0]   cbuf_r, cbuf_nxt;
    logic                bload_r, bload_nxt;

    // pin side
    logic [WAKE_W-1:0]   pd_r, pd_nxt;
    logic [PORT_W-1:0]   dir_r, dir_nxt;
    logic                test_r, test_nxt;
    logic [WAKE_W-1:0]   wake_lvl;
    logic                test_lvl;
    logic                wake;

    // stack access and interrupt choice
    logic                st_wr;
    logic [PC_W-1:0]     st_wdata;
    logic [IDX_W-1:0]    st_idx;
    logic [PC_W-1:0]     st_rdata;
    logic                irq_any;
    logic [PC_W-1:0]     irq_vec;

    // wake-up pins come from outside the clock domain
    pin_sync #(
        .W     (WAKE_W)
    ) u_wake_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .pin   (WAKEUP_INPUT_PORT),
        .level (wake_lvl)
    );

    // test pin is a pin too, same treatment
    pin_sync #(
        .W     (1)
    ) u_test_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .pin   (TEST_PIN),
        .level (test_lvl)
    );

    // fifteen return slots
    return_stack #(
        .DEPTH   (SLOTS)
    ) u_stack (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .idx     (st_idx),
        .wr_en   (st_wr),
        .wr_data (st_wdata),
        .rd_data (st_rdata)
    );

    // fixed priority: external, timer, periodic, serial
    always_comb begin
        irq_any = IRQ_EXT | IRQ_TMR | IRQ_PER | IRQ_SER;
        if (IRQ_EXT) begin
            irq_vec = VEC_EXT;
        end else if (IRQ_TMR) begin
            irq_vec = VEC_TMR;
        end else if (IRQ_PER) begin
            irq_vec = VEC_PER;
        end else begin
            irq_vec = VEC_SER;
        end
    end

    // any high wake pin ends standby
    assign wake = |wake_lvl;

    // sequencer: next counter, index, stack access and fetch
    always_comb begin
        state_nxt   = state_r;
        pc_nxt      = pc_r;
        idx_nxt     = idx_r;
        addr_nxt    = pc_r;
        fetch_nxt   = fetch_r;
        fvalid_nxt  = 1'b0;
        cbuf_nxt    = cbuf_r;
        bload_nxt   = 1'b0;
        afault_nxt  = afault_r;
        st_wr       = 1'b0;
        st_wdata    = pc_r + 13'h0001;
        st_idx      = idx_r;
        // an interrupt beats a valid op in the same cycle
        unique case (state_r)
            ST_RUN: begin
                fetch_nxt  = ROM_DATA;
                fvalid_nxt = 1'b1;
                if (irq_any) begin
                    // push current address so the interrupted word reruns
                    st_idx   = idx_r - 4'h1;
                    idx_nxt  = idx_r - 4'h1;
                    st_wr    = 1'b1;
                    st_wdata = pc_r;
                    pc_nxt   = irq_vec;
                    fvalid_nxt = 1'b0;
                end else if (OP_VALID) begin
                    unique case (OP_CLASS)
                        OP_JUMP: begin
                            pc_nxt = OP_ADDR;
                        end
                        OP_JUMP_IND: begin
                            pc_nxt = INDIRECT_POINTER_REG;
                        end
                        OP_CALL: begin
                            st_idx  = idx_r - 4'h1;
                            idx_nxt = idx_r - 4'h1;
                            st_wr   = 1'b1;
                            pc_nxt  = {2'b00, OP_ADDR[PAGE_LO-1:0]};
                        end
                        OP_CALL_IND: begin
                            st_idx  = idx_r - 4'h1;
                            idx_nxt = idx_r - 4'h1;
                            st_wr   = 1'b1;
                            pc_nxt  = INDIRECT_POINTER_REG;
                        end
                        OP_TABLE: begin
                            // save return, then fetch the constant word
                            st_idx    = idx_r - 4'h1;
                            idx_nxt   = idx_r - 4'h1;
                            st_wr     = 1'b1;
                            pc_nxt    = INDIRECT_POINTER_REG;
                            addr_nxt  = INDIRECT_POINTER_REG;
                            state_nxt = ST_TABLE;
                        end
                        OP_RET, OP_RET_SKIP, OP_RET_INT: begin
                            pc_nxt  = st_rdata;
                            idx_nxt = idx_r + 4'h1;
                        end
                        OP_STOP: begin
                            pc_nxt    = pc_r + 13'h0001;
                            state_nxt = ST_STOP;
                        end
                        OP_HALT: begin
                            pc_nxt    = pc_r + 13'h0001;
                            state_nxt = ST_HALT;
                        end
                        default: begin
                            pc_nxt = pc_r + 13'h0001;
                        end
                    endcase
                end
            end
            ST_TABLE: begin
                // memory word at pointer goes to the buffer, then return
                cbuf_nxt  = ROM_DATA;
                bload_nxt = 1'b1;
                pc_nxt    = st_rdata;
                idx_nxt   = idx_r + 4'h1;
                state_nxt = ST_RUN;
            end
            ST_HALT, ST_STOP: begin
                // ops and interrupts wait for a wake pin
                if (wake) begin
                    state_nxt = ST_RUN;
                end
            end
        endcase
        // the bus keeps the pointer while a table read runs
        addr_nxt = (state_nxt == ST_TABLE) ? addr_nxt : pc_nxt;
        // sticky until reset so a late poll still sees it
        if (pc_nxt > MEM_TOP) begin
            afault_nxt = 1'b1;
        end
        halted_nxt  = (state_nxt == ST_HALT);
        stopped_nxt = (state_nxt == ST_STOP);
    end

    // port defaults: pull-downs fixed, direction latch set to all inputs on stop
    always_comb begin
        pd_nxt   = pd_r;
        dir_nxt  = dir_r;
        test_nxt = test_lvl;
        if (PORT_DIR_WR) begin
            dir_nxt = PORT_DIR_SET;
        end
        // entering stop wins over a port write
        if (state_nxt == ST_STOP && state_r != ST_STOP) begin
            dir_nxt = '1;
        end
    end

    // fault reset is same-domain logic; treated as a synchronous reset
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r   <= ST_RUN;
            pc_r      <= RESET_PC;
            idx_r     <= IDX_RESET;
            addr_r    <= RESET_PC;
            afault_r  <= 1'b0;
            halted_r  <= 1'b0;
            stopped_r <= 1'b0;
        end else if (FAULT_RESET) begin
            state_r   <= ST_RUN;
            pc_r      <= RESET_PC;
            idx_r     <= IDX_RESET;
            addr_r    <= RESET_PC;
            afault_r  <= 1'b0;
            halted_r  <= 1'b0;
            stopped_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            pc_r      <= pc_nxt;
            idx_r     <= idx_nxt;
            addr_r    <= addr_nxt;
            afault_r  <= afault_nxt;
            halted_r  <= halted_nxt;
            stopped_r <= stopped_nxt;
        end
    end

    // a fault reset keeps the last words, only the strobes drop
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fetch_r  <= '0;
            fvalid_r <= 1'b0;
            cbuf_r   <= '0;
            bload_r  <= 1'b0;
        end else if (FAULT_RESET) begin
            fvalid_r <= 1'b0;
            bload_r  <= 1'b0;
        end else begin
            fetch_r  <= fetch_nxt;
            fvalid_r <= fvalid_nxt;
            cbuf_r   <= cbuf_nxt;
            bload_r  <= bload_nxt;
        end
    end

    // pull-down and direction defaults come back on either reset kind; test mode follows the pin on a fault reset
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pd_r   <= '1;
            dir_r  <= '1;
            test_r <= 1'b0;
        end else if (FAULT_RESET) begin
            pd_r   <= '1;
            dir_r  <= '1;
            test_r <= test_nxt;
        end else begin
            pd_r   <= pd_nxt;
            dir_r  <= dir_nxt;
            test_r <= test_nxt;
        end
    end

    // every output straight from a flip-flop
    assign ROM_ADDR           = addr_r;
    assign FETCH_WORD         = fetch_r;
    assign FETCH_VALID        = fvalid_r;
    assign CONSTANT_BUFFER    = cbuf_r;
    assign BUFFER_LOAD        = bload_r;
    assign PC                 = pc_r;
    assign STACK_INDEX        = idx_r;
    assign HALTED             = halted_r;
    assign STOPPED            = stopped_r;
    assign ADDR_FAULT         = afault_r;
    assign WAKEUP_PULLDOWN_EN = pd_r;
    assign PORT_DIR_INPUT     = dir_r;
    assign TEST_MODE          = test_r;
endmodule // program_sequencer

/* File: verif/program_sequencer_sva.sv */
// concurrent checks on the program sequencer top ports
// assumes one core clock and the async active-low reset
module program_sequencer_sva
    import seq_pkg::*;
(
    // clock and resets
    input wire logic                 CORE_CLK,
    input wire logic                 RST_N,
    input wire logic                 FAULT_RESET,
    // decoder and interrupts
    input wire seq_pkg::op_t         OP_CLASS,
    input wire logic                 OP_VALID,
    input wire logic [PC_W-1:0]      OP_ADDR,
    input wire logic [PC_W-1:0]      INDIRECT_POINTER_REG,
    input wire logic                 IRQ_EXT,
    input wire logic                 IRQ_TMR,
    input wire logic                 IRQ_PER,
    input wire logic                 IRQ_SER,
    // memory side and status
    input wire logic [WORD_W-1:0]    ROM_DATA,
    input wire logic [PC_W-1:0]      ROM_ADDR,
    input wire logic [WORD_W-1:0]    CONSTANT_BUFFER,
    input wire logic                 BUFFER_LOAD,
    input wire logic [PC_W-1:0]      PC,
    input wire logic [IDX_W-1:0]     STACK_INDEX,
    input wire logic                 HALTED,
    input wire logic                 STOPPED,
    input wire logic [WAKE_W-1:0]    WAKEUP_PULLDOWN_EN,
    input wire logic [PORT_W-1:0]    PORT_DIR_INPUT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    logic irq;
    logic run;
    logic op_go;
    logic tbl_r;
    logic tbl_nxt;

    // table read blocks the next cycle, so ops there are not taken
    always_comb begin
        irq     = IRQ_EXT | IRQ_TMR | IRQ_PER | IRQ_SER;
        run     = !FAULT_RESET && !HALTED && !STOPPED && !tbl_r;
        op_go   = run && OP_VALID && !irq;
        tbl_nxt = op_go && OP_CLASS == OP_TABLE;
    end

    // registers the table-read marker
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tbl_r <= 1'b0;
        end else begin
            tbl_r <= tbl_nxt;
        end
    end

    a_jump_full_addr: assert property (op_go && OP_CLASS == OP_JUMP |=> PC == $past(OP_ADDR))
        else $error("direct jump target wrong");
    a_call_page_zero: assert property (op_go && OP_CLASS == OP_CALL |=>
        PC == ($past(OP_ADDR) & 13'h07FF) && STACK_INDEX == $past(STACK_INDEX) - 4'h1)
        else $error("direct call target or index wrong");
    a_indirect_ptr: assert property (op_go && OP_CLASS inside {OP_JUMP_IND, OP_CALL_IND}
        |=> PC == $past(INDIRECT_POINTER_REG))
        else $error("indirect target wrong");
    a_step_by_one: assert property (op_go && OP_CLASS == OP_NEXT |=> PC == $past(PC) + 13'h1)
        else $error("counter did not step by one");
    a_ext_first: assert property (run && IRQ_EXT |=>
        PC == VEC_EXT && STACK_INDEX == $past(STACK_INDEX) - 4'h1)
        else $error("external vector or push wrong");
    a_serial_last: assert property (run && IRQ_SER && !(IRQ_EXT | IRQ_TMR | IRQ_PER) |=> PC == VEC_SER)
        else $error("serial vector wrong");
    a_return_pop: assert property (op_go && OP_CLASS inside {OP_RET, OP_RET_SKIP, OP_RET_INT}
        |=> STACK_INDEX == $past(STACK_INDEX) + 4'h1)
        else $error("return index wrong");
    a_table_fetch: assert property (op_go && OP_CLASS == OP_TABLE |=>
        ROM_ADDR == $past(INDIRECT_POINTER_REG) ##1 BUFFER_LOAD && CONSTANT_BUFFER == $past(ROM_DATA)
        ##1 !BUFFER_LOAD)
        else $error("table read word wrong");
    a_fault_defaults: assert property (FAULT_RESET |=>
        PC == RESET_PC && STACK_INDEX == IDX_RESET && PORT_DIR_INPUT == 4'hF)
        else $error("fault reset state wrong");
    a_stop_inputs: assert property (op_go && OP_CLASS == OP_STOP |=> STOPPED && PORT_DIR_INPUT == 4'hF)
        else $error("clock stop port state wrong");
    a_pulldown_held: assert property (WAKEUP_PULLDOWN_EN == 4'hF)
        else $error("wake pull-down dropped");
    a_reset_start: assert property ($rose(RST_N) |-> PC == RESET_PC && STACK_INDEX == IDX_RESET)
        else $error("reset start state wrong");
endmodule // program_sequencer_sva

bind program_sequencer program_sequencer_sva u_sva (
    .CORE_CLK, .RST_N, .FAULT_RESET, .OP_CLASS, .OP_VALID, .OP_ADDR, .INDIRECT_POINTER_REG,
    .IRQ_EXT, .IRQ_TMR, .IRQ_PER, .IRQ_SER, .ROM_DATA, .ROM_ADDR, .CONSTANT_BUFFER, .BUFFER_LOAD,
    .PC, .STACK_INDEX, .HALTED, .STOPPED, .WAKEUP_PULLDOWN_EN, .PORT_DIR_INPUT
);

/* File: verif/rom_model.sv */
// program memory model, one 16-bit word per address
// assumes a zero-latency read; contents derive from the address
module rom_model (
    // read port
    input  wire logic [12:0] rom_addr,
    output logic      [15:0] rom_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // upper bits are the inverted low three address bits so a wrong fetch address shows
    assign rom_data = {~rom_addr[2:0], rom_addr};
endmodule // rom_model

/* File: verif/tb_program_sequencer.sv */
// self-checking bench for the program sequencer
// assumes rom_model stands on the memory side; irq pulses come from here
module tb_program_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import seq_pkg::*;

    logic        clk, rst_n, fault, op_valid, irq_e, irq_t, irq_p, irq_s, test_pin, dir_wr;
    logic        fetch_valid, bload, halted, stopped, addr_fault, test_mode;
    op_t         op;
    logic [12:0] op_addr, ptr, rom_addr, pc;
    logic [15:0] rom_data, fetch_word, cbuf;
    logic [3:0]  idx, wake, pulld, dir_in, dir_set;
    int          mismatches, n_tests;

    program_sequencer dut (.CORE_CLK(clk), .RST_N(rst_n), .FAULT_RESET(fault), .OP_CLASS(op),
        .OP_VALID(op_valid), .OP_ADDR(op_addr), .INDIRECT_POINTER_REG(ptr), .IRQ_EXT(irq_e),
        .IRQ_TMR(irq_t), .IRQ_PER(irq_p), .IRQ_SER(irq_s), .ROM_DATA(rom_data), .ROM_ADDR(rom_addr),
        .FETCH_WORD(fetch_word), .FETCH_VALID(fetch_valid), .CONSTANT_BUFFER(cbuf), .BUFFER_LOAD(bload),
        .PC(pc), .STACK_INDEX(idx), .HALTED(halted), .STOPPED(stopped), .ADDR_FAULT(addr_fault),
        .WAKEUP_INPUT_PORT(wake), .TEST_PIN(test_pin), .WAKEUP_PULLDOWN_EN(pulld),
        .PORT_DIR_INPUT(dir_in), .PORT_DIR_SET(dir_set), .PORT_DIR_WR(dir_wr), .TEST_MODE(test_mode));
    rom_model u_rom (.rom_addr(rom_addr), .rom_data(rom_data));

    // 4 ns core clock
    always #2 clk = ~clk;

    task automatic report_and_stop();
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // inputs move on the falling edge, held across one rising edge
    task automatic issue(input op_t c, input logic [12:0] a);
        @(negedge clk);
        op = c;
        op_addr = a;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
    endtask

    task automatic irq(input logic [3:0] m);
        @(negedge clk);
        {irq_e, irq_t, irq_p, irq_s} = m;
        @(negedge clk);
        {irq_e, irq_t, irq_p, irq_s} = 4'h0;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
    endtask

    // wake pins pass a synchroniser, so allow a bounded number of cycles
    task automatic wake_up(input logic [3:0] w);
        wake = w;
        for (int k = 0; k < 20 && (halted | stopped); k++) @(negedge clk);
        check(16'(halted | stopped), 16'h0000);
        if (halted | stopped) report_and_stop();
        wake = 4'h0;
    endtask

    task automatic t_reset();
        check(16'(pc), 16'h0000);
        check(16'(idx), 16'h000F);
        check(16'(pulld), 16'h000F);
        check(16'(dir_in), 16'h000F);
        check(16'(test_mode), 16'h0000);
    endtask

    task automatic t_flow();
        op_t rk[3] = '{OP_RET, OP_RET_SKIP, OP_RET_INT};
        issue(OP_NEXT, 13'h0000);
        check(16'(pc), 16'h0001);
        check(fetch_word, 16'hE000);
        check(16'(fetch_valid), 16'h0001);
        check(16'(rom_addr), 16'h0001);
        issue(OP_JUMP, 13'h1ABC);
        check(16'(pc), 16'h1ABC);
        issue(OP_CALL, 13'h1F00);
        check(16'(pc), 16'h0700);
        check(16'(idx), 16'h000E);
        issue(OP_NEXT, 13'h0000);
        issue(OP_RET, 13'h0000);
        check(16'(pc), 16'h1ABD);
        check(16'(idx), 16'h000F);
        // every return kind after a call in page 0
        for (int k = 0; k < 3; k++) begin
            issue(OP_CALL, 13'h0100 + 13'(k));
            issue(rk[k], 13'h0000);
            check(16'(pc), 16'h1ABE + 16'(k));
        end
    endtask

    task automatic t_indirect();
        ptr = 13'h1FFE;
        issue(OP_JUMP_IND, 13'h0000);
        check(16'(pc), 16'h1FFE);
        ptr = 13'h17FF;
        issue(OP_CALL_IND, 13'h0000);
        check(16'(pc), 16'h17FF);
        issue(OP_RET, 13'h0000);
        check(16'(pc), 16'h1FFF);
        check(16'(addr_fault), 16'h0000);
    endtask

    task automatic t_table();
        issue(OP_JUMP, 13'h0040);
        ptr = 13'h0123;
        issue(OP_TABLE, 13'h0000);
        @(negedge clk);
        check(16'(bload), 16'h0001);
        check(cbuf, {3'b100, 13'h0123});
        check(16'(pc), 16'h0041);
        check(16'(idx), 16'h000F);
        @(negedge clk);
        check(16'(bload), 16'h0000);
    endtask

    // all sources together, then fewer, so priority and each vector show
    task automatic t_irq();
        for (int i = 0; i < 4; i++) begin
            issue(OP_JUMP, 13'h0200 + 13'(i));
            irq(4'hF >> i);
            check(16'(pc), 16'h0004 - 16'(i));
            check(16'(idx), 16'h000E);
            issue(OP_RET_INT, 13'h0000);
            check(16'(pc), 16'h0200 + 16'(i));
        end
    endtask

    task automatic t_standby();
        issue(OP_HALT, 13'h0000);
        check(16'(halted), 16'h0001);
        issue(OP_JUMP, 13'h0555);
        check(16'(pc), 16'h0204);
        wake_up(4'h2);
        @(negedge clk);
        dir_set = 4'h0;
        dir_wr = 1'b1;
        @(negedge clk);
        dir_wr = 1'b0;
        check(16'(dir_in), 16'h0000);
        issue(OP_STOP, 13'h0000);
        check(16'(stopped), 16'h0001);
        check(16'(dir_in), 16'h000F);
        check(16'(pulld), 16'h000F);
        wake_up(4'h8);
    endtask

    // synchroniser plus register, about five cycles
    task automatic t_test();
        test_pin = 1'b1;
        repeat (6) @(negedge clk);
        check(16'(test_mode), 16'h0001);
        test_pin = 1'b0;
        repeat (6) @(negedge clk);
        check(16'(test_mode), 16'h0000);
    endtask

    task automatic t_fault();
        issue(OP_CALL, 13'h0123);
        fault = 1'b1;
        @(negedge clk);
        fault = 1'b0;
        t_reset();
        issue(OP_JUMP, 13'h0333);
        issue(OP_RET, 13'h0000);
        check(16'(pc), 16'(UNDEF_RET));
    endtask

    // hang guard
    initial begin
        #100us;
        mismatches++;
        report_and_stop();
    end

    initial begin
        {clk, fault, op_valid, irq_e, irq_t, irq_p, irq_s, test_pin, dir_wr} = '0;
        {op_addr, ptr, wake, dir_set, mismatches, n_tests} = '0;
        op = OP_NEXT;
        do_reset();
        t_reset();
        t_flow();
        t_indirect();
        t_table();
        t_irq();
        t_standby();
        t_test();
        t_fault();
        do_reset();
        t_reset();
        report_and_stop();
    end
endmodule // tb_program_sequencer
